/* File: hw/sdbl_pkg.sv */
// Shared constants and types for the single-wire debug link.
package sdbl_pkg;
    localparam int BIT_CYCLES = 16;
    localparam int SAMPLE_AT = 10;
    // Synchroniser lag, credited back so the perceived bit start stays within a cycle of the pin edge.
    localparam int EDGE_LAG = 2;
    localparam int SPEEDUP_AT = 7;
    localparam int DRIVE0_CYCLES = 13;
    localparam int TIMEOUT_CYCLES = 512;
    localparam int SYNC_MIN_LOW = 128;
    localparam int SYNC_DELAY = 16;
    localparam int SYNC_PULSE = 128;
    localparam int CMD_DELAY = 16;
    localparam int HOST_LOW_RX = 4;
    localparam int HOST_LOW_TX1 = 4;
    localparam int SYNC_WAIT_MAX = 255;

    typedef enum logic [1:0] {SDBL_REQ_SEND, SDBL_REQ_RECV, SDBL_REQ_SYNC, SDBL_REQ_DELAY} sdbl_req_type;

    // Halted-mode command codes all have the top bit clear.
    function automatic logic sdbl_is_halted_cmd(input logic [7:0] code);
        return ~code[7];
    endfunction : sdbl_is_halted_cmd
endpackage : sdbl_pkg

/* File: hw/sdbl_if.sv */
// Pseudo-open-drain debug pin shared by the pod and the device.
`timescale 1ns/1ns
interface sdbl_if;
    logic pod_o;
    logic pod_oe;
    logic dev_o;
    logic dev_oe;
    logic debug_pin;

    // Pull-up keeps the pin high; any low drive wins over a speedup pulse.
    assign debug_pin = !((pod_oe && !pod_o) || (dev_oe && !dev_o));

    modport dev (input debug_pin, output dev_o, output dev_oe);
    modport pod (input debug_pin, output pod_o, output pod_oe);
endinterface : sdbl_if

/* File: hw/sdbl_dev.sv */
// Device end of the single-wire debug link: bit engine, timeout, sync reply and boot mode.
// Function
// R1: Host starts every bit with falling edge.
// R2: Bits MSB first, sixteen debug cycles each.
// R3: Time out after 512 cycles between edges.
// R4: Timeout abandons command, memory and mode untouched.
// R5: Control bit selects bus or alternate clock.
// R6: Sample pin ten cycles after synchronised edge.
// R7: Device never drives during host-to-device bits.
// R8: Host holds pin low two cycles minimum.
// R9: Logic one gets speedup pulse at seven.
// R10: Host samples about ten cycles after edge.
// R11: Logic zero driven low thirteen cycles, then speedup.
// R12: Halted-mode commands only while CPU halted.
// R13: Non-intrusive commands accepted at any time.
// R14: Halted commands give register, step, resume access.
// R15: Pin level at reset selects boot mode.
// R16: Pulled-up idle pin means normal boot.
// R17: Link works without a prior reset.
// R18: No memory map or peripheral use.
// R19: Speed probe answered with timed pulse.
// R20: Both sides drive short high speedup pulses.
// R21: Host probe is long low, speedup, release.
// R22: Probe reply: wait 16, low 128, pulse.
// R23: Delay element means wait sixteen cycles.
// R24: Pin passes two-stage synchroniser before use.
`timescale 1ns/1ns
module sdbl_dev
    import sdbl_pkg::*;
#(
    parameter int TIMEOUT = TIMEOUT_CYCLES
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic alt_tick,
    input wire logic debug_clock_select,
    input wire logic halted,
    input wire logic cmd_done,
    sdbl_if.dev link,
    output logic [7:0] rx_data,
    output logic rx_is_cmd,
    output logic rx_valid,
    input wire logic rx_ready,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    output logic bgnd_start,
    output logic timeout_pulse,
    output logic cmd_rejected,
    output logic sync_seen
);
    typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_TX, ST_SYNC_HI, ST_SYNC_DLY, ST_SYNC_LOW, ST_SYNC_PUL} sdbl_st_type;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        sdbl_st_type st;
        logic [7:0] cnt;
        logic [9:0] to_cnt;
        logic [2:0] bitcnt;
        logic [7:0] rx_sh;
        logic [7:0] tx_sh;
        logic tx_loaded;
        logic in_cmd;
        logic ignore;
        logic [8:0] e0;
        logic [8:0] e1;
        logic v0;
        logic v1;
        logic o;
        logic oe;
        logic tx_rdy;
        logic bgnd;
        logic tmo;
        logic rej;
        logic syncp;
    } sdbl_dev_type;

    localparam sdbl_dev_type DEV_RST = '{s1: 1'b1, s2: 1'b1, s3: 1'b1, st: ST_IDLE, tx_rdy: 1'b1, default: '0};

    sdbl_dev_type r;
    sdbl_dev_type n;
    logic tick;
    logic fall;
    logic [7:0] c;
    logic [7:0] byte_in;
    logic first;
    logic drop;
    logic push;
    logic pop;
    logic busy;

    // R5 bus or alternate clock
    assign tick = ce && (debug_clock_select ? alt_tick : 1'b1);
    // R24 edge after synchroniser
    assign fall = r.s3 && !r.s2;
    assign c = r.cnt + 8'h01;

    always_comb
    begin
        n = r;
        n.tmo = 1'b0;
        n.rej = 1'b0;
        n.syncp = 1'b0;
        push = 1'b0;
        byte_in = {r.rx_sh[6:0], r.s2};
        first = !r.in_cmd;
        drop = 1'b0;
        busy = (r.bitcnt != 3'h0) || r.tx_loaded || r.in_cmd;
        // R24 two-stage synchroniser
        n.s1 = link.debug_pin;
        n.s2 = r.s1;
        if (cmd_done)
        begin
            n.in_cmd = 1'b0;
            n.ignore = 1'b0;
        end
        if (r.st == ST_IDLE && !r.tx_loaded && r.bitcnt == 3'h0 && tx_valid && r.tx_rdy && r.in_cmd)
        begin
            n.tx_sh = tx_data;
            n.tx_loaded = 1'b1;
        end
        if (tick)
        begin
            n.s3 = r.s2;
            n.cnt = c;
            if (fall || !busy)
                n.to_cnt = '0;
            else if (r.st inside {ST_IDLE, ST_RX, ST_TX})
                n.to_cnt = r.to_cnt + 10'h001;
            unique case (r.st)
                ST_IDLE:
                begin
                    n.oe = 1'b0;
                    // R1 bit opens on host falling edge
                    // R6 count from pin edge
                    if (fall && r.tx_loaded)
                    begin
                        n.st = ST_TX;
                        n.cnt = 8'(EDGE_LAG);
                        n.oe = !r.tx_sh[7];
                        n.o = 1'b0;
                    end
                    else if (fall && (r.bitcnt != 3'h0 || !r.v1))
                    begin
                        n.st = ST_RX;
                        n.cnt = 8'(EDGE_LAG);
                    end
                end
                ST_RX:
                begin
                    // R7 never driven while receiving
                    n.oe = 1'b0;
                    // R6 sample ten cycles after start
                    if (c == 8'(SAMPLE_AT))
                    begin
                        // R2 MSB first shift
                        n.rx_sh = byte_in;
                        n.bitcnt = r.bitcnt + 3'h1;
                        if (r.bitcnt == 3'h7)
                        begin
                            n.in_cmd = 1'b1;
                            // R12 halted-mode gate
                            // R13 non-intrusive always pass
                            if (first && sdbl_is_halted_cmd(byte_in) && !halted)
                            begin
                                drop = 1'b1;
                                n.ignore = 1'b1;
                                n.rej = 1'b1;
                            end
                            // R14 halted commands forwarded while halted
                            push = !(drop || r.ignore);
                        end
                    end
                    else if (c > 8'(SAMPLE_AT) && r.s2)
                        n.st = ST_IDLE;
                    // R19 long low is a speed probe
                    else if (c == 8'(SYNC_MIN_LOW))
                    begin
                        n.st = ST_SYNC_HI;
                        n.bitcnt = '0;
                        n.in_cmd = 1'b0;
                        n.ignore = 1'b0;
                        n.tx_loaded = 1'b0;
                    end
                end
                ST_TX:
                begin
                    if (r.tx_sh[7])
                    begin
                        // R9 speedup pulse at seven
                        n.oe = (c == 8'(SPEEDUP_AT));
                        n.o = 1'b1;
                    end
                    else
                    begin
                        // R11 low thirteen then speedup
                        n.oe = (c <= 8'(DRIVE0_CYCLES));
                        n.o = (c == 8'(DRIVE0_CYCLES));
                    end
                    // R2 bit ends early to catch next edge
                    if (c == 8'(DRIVE0_CYCLES + 1))
                    begin
                        n.oe = 1'b0;
                        n.st = ST_IDLE;
                        n.tx_sh = {r.tx_sh[6:0], 1'b0};
                        n.bitcnt = r.bitcnt + 3'h1;
                        if (r.bitcnt == 3'h7)
                            n.tx_loaded = 1'b0;
                    end
                end
                ST_SYNC_HI:
                begin
                    // R22 wait for pin to return high
                    n.cnt = '0;
                    if (r.s2)
                        n.st = ST_SYNC_DLY;
                end
                ST_SYNC_DLY:
                begin
                    if (c == 8'(SYNC_DELAY))
                    begin
                        n.st = ST_SYNC_LOW;
                        n.cnt = '0;
                        n.oe = 1'b1;
                        n.o = 1'b0;
                    end
                end
                ST_SYNC_LOW:
                begin
                    // R22 low 128 cycles then pulse
                    if (c == 8'(SYNC_PULSE))
                    begin
                        n.st = ST_SYNC_PUL;
                        n.o = 1'b1;
                    end
                end
                ST_SYNC_PUL:
                begin
                    // R20 one-cycle speedup then release
                    n.oe = 1'b0;
                    n.o = 1'b0;
                    n.st = ST_IDLE;
                    n.syncp = 1'b1;
                end
                default:
                    n.st = ST_IDLE;
            endcase
            // R3 inactivity timeout
            // R4 abort leaves buffer and mode alone
            if (busy && r.to_cnt == 10'(TIMEOUT - 1) && !fall && r.st inside {ST_IDLE, ST_RX, ST_TX})
            begin
                n.st = ST_IDLE;
                n.oe = 1'b0;
                n.bitcnt = '0;
                n.tx_loaded = 1'b0;
                n.in_cmd = 1'b0;
                n.ignore = 1'b0;
                n.to_cnt = '0;
                n.tmo = 1'b1;
                push = 1'b0;
            end
        end
        // Two-entry buffer: a full buffer holds off the start of the next byte.
        pop = r.v0 && rx_ready;
        if (pop)
        begin
            n.e0 = r.v1 ? r.e1 : {first, byte_in};
            n.v0 = r.v1 || push;
            n.v1 = r.v1 && push;
            if (r.v1)
                n.e1 = {first, byte_in};
        end
        else if (push)
        begin
            if (!r.v0)
            begin
                n.e0 = {first, byte_in};
                n.v0 = 1'b1;
            end
            else
            begin
                n.e1 = {first, byte_in};
                n.v1 = 1'b1;
            end
        end
        n.tx_rdy = !n.tx_loaded;
    end

    // R17 link runs from any state, no reset needed to attach
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            r <= DEV_RST;
            r.s1 <= link.debug_pin;
            r.s2 <= r.s1;
            // R15 pin level caught during reset
            // R16 pulled-up pin gives normal boot
            r.bgnd <= !r.s2;
        end
        else if (ce)
            r <= n;
    end

    // R18 only pin and local ports, no bus access
    assign link.dev_o = r.o;
    assign link.dev_oe = r.oe;
    assign rx_data = r.e0[7:0];
    assign rx_is_cmd = r.e0[8];
    assign rx_valid = r.v0;
    assign tx_ready = r.tx_rdy;
    assign bgnd_start = r.bgnd;
    assign timeout_pulse = r.tmo;
    assign cmd_rejected = r.rej;
    assign sync_seen = r.syncp;
endmodule : sdbl_dev

/* File: hw/sdbl_pod.sv */
// Pod end of the single-wire debug link: bit sender, bit reader, speed probe and delay.
`timescale 1ns/1ns
module sdbl_pod
    import sdbl_pkg::*;
#(
    parameter int HOST_SYNC_LOW = 2 * SYNC_MIN_LOW
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ce,
    sdbl_if.pod link,
    input wire logic req_valid,
    input wire sdbl_req_type req_kind,
    input wire logic [7:0] req_data,
    output logic req_ready,
    output logic resp_valid,
    output logic [15:0] resp_data
);
    typedef enum logic [2:0] {P_IDLE, P_BIT, P_SYNC_LOW, P_SYNC_PUL, P_SYNC_WF, P_SYNC_MEAS, P_DELAY} sdbl_pst_type;

    typedef struct packed {
        sdbl_pst_type st;
        logic send;
        logic [15:0] cnt;
        logic [2:0] bitcnt;
        logic [7:0] sh;
        logic o;
        logic oe;
        logic rdy;
        logic rv;
        logic [15:0] rd;
    } sdbl_pod_type;

    localparam sdbl_pod_type POD_RST = '{st: P_IDLE, rdy: 1'b1, default: '0};

    sdbl_pod_type r;
    sdbl_pod_type n;
    logic [15:0] c;
    logic [15:0] low_end;

    assign c = r.cnt + 16'h0001;
    assign low_end = r.sh[7] ? 16'(HOST_LOW_TX1) : 16'(DRIVE0_CYCLES);

    always_comb
    begin
        n = r;
        n.rv = 1'b0;
        n.cnt = c;
        unique case (r.st)
            P_IDLE:
            begin
                n.cnt = '0;
                n.oe = 1'b0;
                if (req_valid)
                begin
                    n.sh = req_data;
                    n.bitcnt = '0;
                    n.send = (req_kind == SDBL_REQ_SEND);
                    n.st = (req_kind == SDBL_REQ_SYNC) ? P_SYNC_LOW :
                           (req_kind == SDBL_REQ_DELAY) ? P_DELAY : P_BIT;
                    // R1 each bit opens with a falling edge
                    n.oe = (req_kind != SDBL_REQ_DELAY);
                    n.o = 1'b0;
                end
            end
            P_BIT:
            begin
                if (r.send)
                begin
                    // R20 speedup after host-driven low
                    n.oe = (c <= low_end);
                    n.o = (c == low_end);
                end
                else
                begin
                    // R8 low long enough to be seen
                    // R9 released before target speedup
                    n.oe = (c < 16'(HOST_LOW_RX));
                    n.o = 1'b0;
                    // R10 sample ten cycles after edge
                    if (c == 16'(SAMPLE_AT))
                        n.sh = {r.sh[6:0], link.debug_pin};
                end
                // R2 sixteen cycles per bit, MSB first
                if (c == 16'(BIT_CYCLES))
                begin
                    n.cnt = '0;
                    if (r.send)
                        n.sh = {r.sh[6:0], 1'b0};
                    n.bitcnt = r.bitcnt + 3'h1;
                    if (r.bitcnt == 3'h7)
                    begin
                        n.oe = 1'b0;
                        n.st = P_IDLE;
                        n.rv = !r.send;
                        n.rd = {8'h00, r.sh};
                    end
                    else
                    begin
                        n.oe = 1'b1;
                        n.o = 1'b0;
                    end
                end
            end
            P_SYNC_LOW:
            begin
                // R21 long low, then one speedup cycle
                if (c == 16'(HOST_SYNC_LOW))
                begin
                    n.o = 1'b1;
                    n.st = P_SYNC_PUL;
                end
            end
            P_SYNC_PUL:
            begin
                n.oe = 1'b0;
                n.o = 1'b0;
                n.cnt = '0;
                n.st = P_SYNC_WF;
            end
            P_SYNC_WF:
            begin
                // R19 wait for the reply pulse, give up after a bound
                if (!link.debug_pin)
                begin
                    n.cnt = 16'h0001;
                    n.st = P_SYNC_MEAS;
                end
                else if (c == 16'(SYNC_WAIT_MAX))
                begin
                    n.st = P_IDLE;
                    n.rv = 1'b1;
                    n.rd = '0;
                end
            end
            P_SYNC_MEAS:
            begin
                if (link.debug_pin || c == 16'hffff)
                begin
                    n.st = P_IDLE;
                    n.rv = 1'b1;
                    n.rd = r.cnt;
                end
            end
            P_DELAY:
            begin
                // R23 delay element of sixteen cycles
                if (c == 16'(CMD_DELAY))
                    n.st = P_IDLE;
            end
            default:
                n.st = P_IDLE;
        endcase
        n.rdy = (n.st == P_IDLE);
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            r <= POD_RST;
        else if (ce)
            r <= n;
    end

    assign link.pod_o = r.o;
    assign link.pod_oe = r.oe;
    assign req_ready = r.rdy;
    assign resp_valid = r.rv;
    assign resp_data = r.rd;
endmodule : sdbl_pod

/* File: verification/sdbl_monitor.sv */
// Wire-level assertion checker for the debug pin between pod and device.
`timescale 1ns/1ns
module sdbl_monitor
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic pod_o,
    input wire logic pod_oe,
    input wire logic dev_o,
    input wire logic dev_oe,
    input wire logic debug_pin
);
    logic [8:0] fall_age_r;
    logic [7:0] low_run_r;
    logic pin_q_r;
    logic low_q_r;
    wire dev_low = dev_oe && !dev_o;
    wire dev_hi = dev_oe && dev_o;

    default clocking mon_cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    // Counters stand in for repetitions far too long to unroll.
    always_ff @(posedge clk)
    begin
        pin_q_r <= debug_pin;
        low_q_r <= dev_low;
        low_run_r <= dev_low ? (low_q_r ? low_run_r + 8'h01 : 8'h01) : low_run_r;
        if (sys_rst)
            fall_age_r <= 9'h1ff;
        else if (pin_q_r && !debug_pin)
            fall_age_r <= 9'h000;
        else if (fall_age_r != 9'h1ff)
            fall_age_r <= fall_age_r + 9'h001;
    end

    AST_DEV_PULSE_ONE: assert property (dev_hi |=> !dev_oe)
        else $error("device speedup pulse lasted more than one cycle");
    AST_POD_PULSE_ONE: assert property (pod_oe && pod_o |=> !pod_oe)
        else $error("pod speedup pulse lasted more than one cycle");
    AST_LOW_LENGTH: assert property (dev_hi && low_q_r |-> (low_run_r == 8'h0b || low_run_r == 8'h80))
        else $error("device low drive had the wrong length");
    AST_ONE_AT_SEVEN: assert property (dev_hi && !$past(dev_oe) |-> fall_age_r inside {[9'h007:9'h00b]})
        else $error("device one pulse off its slot after the edge");
    AST_HOST_RELEASED: assert property (dev_hi && !$past(dev_oe) |-> !pod_oe)
        else $error("pod still driving at the device one pulse");
    AST_HOST_LOW_TWO: assert property ($rose(pod_oe) |-> (pod_oe && !pod_o) [*2])
        else $error("pod bit start low shorter than two cycles");
    AST_SYNC_DELAY: assert property ($fell(debug_pin) && !dev_oe |=> !dev_oe)
        else $error("device reacted to the pin without synchroniser delay");
    AST_DRIVE_AFTER_EDGE: assert property ($rose(dev_oe) && !dev_o |-> (fall_age_r <= 9'h005 || fall_age_r >= 9'h096))
        else $error("device began a low drive without a pod edge");
endmodule : sdbl_monitor

/* File: verification/tb.sv */
// Bench joining the pod and device ends over the debug pin interface.
`timescale 1ns/1ns
module tb;
    import sdbl_pkg::*;
    // Must exceed the probe's low time, or the probe itself times out.
    localparam int TMO = 192;
    logic clk, sys_rst, alt_tick, debug_clock_select, halted, cmd_done, rx_ready, tx_valid, req_valid;
    logic rx_is_cmd, rx_valid, tx_ready, bgnd_start, timeout_pulse, cmd_rejected, sync_seen;
    logic req_ready, resp_valid, sending, pin_q;
    logic [7:0] rx_data, tx_data, req_data;
    logic [15:0] resp_data;
    sdbl_req_type req_kind;
    int error_cnt, check_count, rej_n, tmo_n, sync_n, cyc, fall_at, tmo_at, drv_n;

    sdbl_if link_if();
    sdbl_dev #(.TIMEOUT(TMO)) sdbl_dev_inst (.clk, .sys_rst, .ce(1'b1), .alt_tick, .debug_clock_select,
        .halted, .cmd_done, .link(link_if.dev), .rx_data, .rx_is_cmd, .rx_valid, .rx_ready, .tx_data,
        .tx_valid, .tx_ready, .bgnd_start, .timeout_pulse, .cmd_rejected, .sync_seen);
    sdbl_pod #(.HOST_SYNC_LOW(140)) sdbl_pod_inst (.clk, .sys_rst, .ce(1'b1), .link(link_if.pod),
        .req_valid, .req_kind, .req_data, .req_ready, .resp_valid, .resp_data);
    sdbl_monitor sdbl_monitor_inst (.clk, .sys_rst, .pod_o(link_if.pod_o), .pod_oe(link_if.pod_oe),
        .dev_o(link_if.dev_o), .dev_oe(link_if.dev_oe), .debug_pin(link_if.debug_pin));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Events are tallied on the falling edge, clear of the launching edge.
    always @(negedge clk)
    begin
        cyc++;
        if (pin_q && !link_if.debug_pin)
            fall_at = cyc;
        pin_q = link_if.debug_pin;
        if (sending && link_if.dev_oe)
            drv_n++;
        if (cmd_rejected === 1'b1)
            rej_n++;
        if (sync_seen === 1'b1)
            sync_n++;
        if (timeout_pulse === 1'b1)
        begin
            tmo_n++;
            tmo_at = cyc;
        end
    end

    task automatic tick;
        @(posedge clk);
        #1;
    endtask : tick

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish

    // A wait that runs out is a mismatch and ends the run at once.
    task automatic wait_on(input string what, ref logic sig);
        for (int n = 0; sig !== 1'b1; n++)
        begin
            if (n > 3000)
            begin
                check(what, 16'h0, 16'h1);
                tally_and_finish();
            end
            tick();
        end
    endtask : wait_on

    task automatic pod_req(input sdbl_req_type kind, input logic [7:0] data);
        tick();
        wait_on("pod ready", req_ready);
        req_kind = kind;
        req_data = data;
        req_valid = 1'b1;
        tick();
        req_valid = 1'b0;
        repeat (2) tick();
    endtask : pod_req

    task automatic pod_send(input logic [7:0] data);
        sending = 1'b1;
        pod_req(SDBL_REQ_SEND, data);
        wait_on("pod idle", req_ready);
        sending = 1'b0;
    endtask : pod_send

    task automatic wait_rx(input logic [7:0] exp, input logic cmd);
        tick();
        wait_on("device byte", rx_valid);
        check("rx data", {8'h00, rx_data}, {8'h00, exp});
        check("rx command mark", {15'h0, rx_is_cmd}, {15'h0, cmd});
        rx_ready = 1'b1;
        tick();
        rx_ready = 1'b0;
    endtask : wait_rx

    task automatic cmd_end;
        tick();
        cmd_done = 1'b1;
        tick();
        cmd_done = 1'b0;
    endtask : cmd_end

    task automatic scen_transfer;
        logic [7:0] b;
        drv_n = 0;
        pod_send(8'h4b);
        wait_rx(8'h4b, 1'b1);
        pod_send(8'ha5);
        wait_rx(8'ha5, 1'b0);
        check("device drive while receiving", 16'(drv_n), 16'h0);
        for (int i = 0; i < 2; i++)
        begin
            b = (i == 0) ? 8'h96 : 8'h3c;
            tick();
            tx_data = b;
            tx_valid = 1'b1;
            wait_on("device ready", tx_ready);
            tick();
            tx_valid = 1'b0;
            pod_req(SDBL_REQ_RECV, 8'h00);
            wait_on("pod reply", resp_valid);
            check("reply byte", {8'h00, resp_data[7:0]}, {8'h00, b});
        end
        check("reply echoed inward", {15'h0, rx_valid}, 16'h0);
        cmd_end();
    endtask : scen_transfer

    task automatic scen_reject;
        int r;
        r = rej_n;
        halted = 1'b0;
        pod_send(8'h10);
        pod_send(8'h22);
        check("rejections", 16'(rej_n - r), 16'h1);
        check("byte while running", {15'h0, rx_valid}, 16'h0);
        cmd_end();
        pod_send(8'he4);
        wait_rx(8'he4, 1'b1);
        cmd_end();
        halted = 1'b1;
    endtask : scen_reject

    task automatic scen_timeout;
        int t;
        t = tmo_n;
        pod_send(8'h6c);
        wait_rx(8'h6c, 1'b1);
        for (int n = 0; tmo_n == t && n < 4 * TMO; n++)
            tick();
        check("timeout delay", 16'(tmo_at - fall_at >= TMO && tmo_at - fall_at <= TMO + 6), 16'h1);
        pod_send(8'h55);
        wait_rx(8'h55, 1'b1);
        cmd_end();
    endtask : scen_timeout

    task automatic scen_probe;
        int s;
        s = sync_n;
        pod_req(SDBL_REQ_SYNC, 8'h00);
        wait_on("probe reply", resp_valid);
        check("probe length", resp_data, 16'(SYNC_PULSE));
        repeat (4) tick();
        check("probe seen", 16'(sync_n - s), 16'h1);
    endtask : scen_probe

    task automatic scen_delay;
        int d;
        pod_req(SDBL_REQ_DELAY, 8'h00);
        for (d = 2; req_ready !== 1'b1 && d < 4 * CMD_DELAY; d++)
            tick();
        check("delay length", 16'(d), 16'(CMD_DELAY));
    endtask : scen_delay

    // The receiver stalls, so the third byte must find the buffer full.
    task automatic scen_buffer;
        pod_send(8'h4c);
        pod_send(8'h12);
        pod_send(8'h34);
        wait_rx(8'h4c, 1'b1);
        wait_rx(8'h12, 1'b0);
        repeat (4) tick();
        check("byte past full buffer", {15'h0, rx_valid}, 16'h0);
        cmd_end();
    endtask : scen_buffer

    task automatic scen_clock_select;
        debug_clock_select = 1'b1;
        alt_tick = 1'b1;
        pod_send(8'hc4);
        wait_rx(8'hc4, 1'b1);
        cmd_end();
        alt_tick = 1'b0;
        pod_send(8'h81);
        check("byte with no debug clock", {15'h0, rx_valid}, 16'h0);
        sys_rst = 1'b1;
        repeat (8) tick();
        sys_rst = 1'b0;
        debug_clock_select = 1'b0;
        check("boot state", {15'h0, bgnd_start}, 16'h0);
        pod_send(8'h4b);
        wait_rx(8'h4b, 1'b1);
    endtask : scen_clock_select

    initial
    begin
        sys_rst = 1'b1;
        alt_tick = 1'b0;
        debug_clock_select = 1'b0;
        halted = 1'b1;
        cmd_done = 1'b0;
        rx_ready = 1'b0;
        tx_valid = 1'b0;
        tx_data = 8'h00;
        req_valid = 1'b0;
        req_kind = SDBL_REQ_SEND;
        req_data = 8'h00;
        sending = 1'b0;
        pin_q = 1'b1;
        repeat (8) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        scen_transfer();
        scen_reject();
        scen_timeout();
        scen_probe();
        scen_delay();
        scen_buffer();
        scen_clock_select();
        tally_and_finish();
    end
endmodule : tb
